/* qpd_pkg.sv */
// Shared constants, field layout and carrier types of the encoder block
package qpd_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_ENC_CTRL  = 8'h00;
    localparam logic [7:0] OFS_FILT_CTRL = 8'h04;
    localparam logic [7:0] OFS_POSITION  = 8'h08;
    localparam logic [7:0] OFS_MAX_LIMIT = 8'h0C;

    // Reset values
    localparam logic [15:0] ENC_CTRL_RESET  = 16'h0000;
    localparam logic [7:0]  FILT_CTRL_RESET = 8'h00;
    localparam logic [15:0] POSITION_RESET  = 16'h0000;
    localparam logic [15:0] MAX_LIMIT_RESET = 16'hFFFF;

    // encoder_control fields
    localparam int BIT_CNT_ERR    = 15;
    localparam int BIT_IDLE_STOP  = 13;
    localparam int BIT_INDEX_PIN  = 12;
    localparam int BIT_DIRECTION  = 11;
    localparam int MODE_LSB       = 8;
    localparam int BIT_SWAP       = 7;
    localparam int BIT_DIR_OE     = 6;
    localparam int BIT_GATE       = 5;
    localparam int PRESCALE_LSB   = 3;
    localparam int BIT_INDEX_RST  = 2;
    localparam int BIT_CLK_SRC    = 1;
    localparam int BIT_DIRECTION_FLAG_SRC   = 0;
    // Plain stored bits; status bits are assembled on read
    localparam logic [15:0] ENC_CTRL_WMASK = 16'h27FF;

    // encoder_mode_select codes
    localparam logic [2:0] MODE_OFF       = 3'h0;
    localparam logic [2:0] MODE_TIMER     = 3'h1;
    localparam logic [2:0] MODE_X2_INDEX  = 3'h4;
    localparam logic [2:0] MODE_X2_MATCH  = 3'h5;
    localparam logic [2:0] MODE_X4_INDEX  = 3'h6;
    localparam logic [2:0] MODE_X4_MATCH  = 3'h7;

    // filter_control fields
    localparam int FILT_DIV_LSB  = 0;
    localparam int BIT_FILT_EN   = 3;
    localparam logic [1:0] FILT_SAMPLES = 2'h3;

    // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PRESCALE_LAST_1   = 8'h00;
    localparam logic [7:0] PRESCALE_LAST_8   = 8'h07;
    localparam logic [7:0] PRESCALE_LAST_64  = 8'h3F;
    localparam logic [7:0] PRESCALE_LAST_256 = 8'hFF;

    typedef struct packed {
        logic index;
        logic phase_b;
        logic phase_a;
    } encoder_pins_s;

    function automatic logic [15:0] merge_bytes(
        input logic [15:0] old_value,
        input logic [15:0] wdata,
        input logic [1:0]  strb
    );
        merge_bytes = {strb[1] ? wdata[15:8] : old_value[15:8],
                       strb[0] ? wdata[7:0]  : old_value[7:0]};
    endfunction

endpackage

/* input_filter.sv */
// Pin synchronisers and programmable noise filters for the encoder pins
module input_filter
    import qpd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    // Pins and settings
    input  wire encoder_pins_s pins_raw,
    input  wire logic [7:0]    filt_ctrl,
    // Filtered levels
    output encoder_pins_s      pins_clean
);

    encoder_pins_s sync1;
    encoder_pins_s sync2;
    logic [7:0]    div_cnt;
    logic [7:0]    div_last;
    logic          sample_tick;
    logic [1:0]    stable_cnt [3];
    logic [2:0]    last_sample;

    assign div_last    = 8'((9'h001 << filt_ctrl[FILT_DIV_LSB +: 3]) - 9'h001);
    assign sample_tick = (div_cnt == div_last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (ce) begin
            sync1 <= pins_raw;
            sync2 <= sync1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 8'h00;
        end else if (ce) begin
            div_cnt <= sample_tick ? 8'h00 : 8'(div_cnt + 8'h01);
        end
    end

    // With the filter enabled, a level passes only after it has held for several sample ticks; disabled, it passes straight through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_cnt  <= '{default: 2'h0};
            last_sample <= 3'h0;
            pins_clean  <= '0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if (!filt_ctrl[BIT_FILT_EN]) begin
                    pins_clean[i] <= sync2[i];
                end else if (sample_tick) begin
                    last_sample[i] <= sync2[i];
                    if (sync2[i] != last_sample[i]) begin
                        stable_cnt[i] <= 2'h1;
                    end else if (stable_cnt[i] != FILT_SAMPLES) begin
                        stable_cnt[i] <= 2'(stable_cnt[i] + 2'h1);
                    end else begin
                        pins_clean[i] <= last_sample[i];
                    end
                end
            end
        end
    end

endmodule // input_filter

/* timer_prescaler.sv */
// Divider for the timer input clock
module timer_prescaler
    import qpd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] select,
    input  wire logic       tick_in,
    // Divided tick
    output logic            tick_out
);

    logic [7:0] count;
    logic [7:0] last;

    always_comb begin
        case (select)
            2'h0:    last = PRESCALE_LAST_1;
            2'h1:    last = PRESCALE_LAST_8;
            2'h2:    last = PRESCALE_LAST_64;
            default: last = PRESCALE_LAST_256;
        endcase
    end

    // At or past the end so a smaller divide takes effect at once
    assign tick_out = run && tick_in && (count >= last);

    // Cleared outside timer mode so each start is aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 8'h00;
        end else if (ce) begin
            if (!run) begin
                count <= 8'h00;
            end else if (tick_in) begin
                count <= (count >= last) ? 8'h00 : 8'(count + 8'h01);
            end
        end
    end

endmodule // timer_prescaler

/* quadrature_position_decoder.sv */
// Quadrature encoder decoder with position counter and APB registers
module quadrature_position_decoder
    import qpd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Encoder pins
    input  wire encoder_pins_s pins_raw,
    // Decoder outputs
    output logic               count_pulse,
    output logic               count_dir,
    output logic               dir_pin_out,
    output logic               dir_pin_oe,
    output logic               irq_request
);

    logic [15:0]   enc_ctrl;
    logic [7:0]    filt_ctrl;
    logic [15:0]   position;
    logic [15:0]   max_limit;
    logic          direction_flag;
    logic          count_error_flag;
    encoder_pins_s pins_clean;
    logic          prev_a;
    logic          prev_b;
    logic          prev_raw_a;
    logic          prev_index;

    logic [2:0]    mode;
    logic          quad_mode;
    logic          timer_mode;
    logic          match_mode;
    logic          cur_a;
    logic          cur_b;
    logic          a_changed;
    logic          b_changed;
    logic          quad_step;
    logic          step_up;
    logic          phase_error;
    logic          index_rise;
    logic          index_reset;
    logic          timer_src;
    logic          timer_tick;
    logic          timer_up;
    logic          count_event;
    logic          count_up;
    logic          match_reset;
    logic [15:0]   next_position;

    logic          access;
    logic          wr;
    logic          hit;
    logic          wr_enc;
    logic          wr_filt;
    logic          wr_pos;
    logic          wr_max;
    logic [15:0]   enc_status;

    input_filter u_filter (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .pins_raw   (pins_raw),
        .filt_ctrl  (filt_ctrl),
        .pins_clean (pins_clean)
    );

    assign mode       = enc_ctrl[MODE_LSB +: 3];
    assign quad_mode  = mode[2];
    assign timer_mode = (mode == MODE_TIMER);
    assign match_mode = (mode == MODE_X2_MATCH) || (mode == MODE_X4_MATCH);

    // Optional swap of the two phases ahead of the decoder
    assign cur_a = enc_ctrl[BIT_SWAP] ? pins_clean.phase_b
                                      : pins_clean.phase_a;
    assign cur_b = enc_ctrl[BIT_SWAP] ? pins_clean.phase_a
                                      : pins_clean.phase_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_a     <= 1'b0;
            prev_b     <= 1'b0;
            prev_raw_a <= 1'b0;
            prev_index <= 1'b0;
        end else if (ce) begin
            prev_a     <= cur_a;
            prev_b     <= cur_b;
            prev_raw_a <= pins_clean.phase_a;
            prev_index <= pins_clean.index;
        end
    end

    assign a_changed   = cur_a ^ prev_a;
    assign b_changed   = cur_b ^ prev_b;
    // Both phases moving at once skips a state: no count, flag it
    assign phase_error = quad_mode && a_changed && b_changed;
    // Mode bit 1 picks x4 over x2
    // x4 takes every single edge, x2 only phase A edges
    assign quad_step   = quad_mode && (mode[1] ? (a_changed ^ b_changed)
                                               : (a_changed && !b_changed));
    // Sequence 00,10,11,01 is forward; reverse order is down
    // Direction read from old B against new A
    assign step_up     = cur_a ^ prev_b;
    assign index_rise  = pins_clean.index && !prev_index;
    // Index reset only in index modes
    // Index reset enable bit gates it
    assign index_reset = quad_mode && !mode[0] && enc_ctrl[BIT_INDEX_RST]
                         && index_rise;

    // Timer source: every cycle, or only while phase A is high when gated, or phase A rising edge
    // Timer settings used only in timer mode
    assign timer_src = enc_ctrl[BIT_CLK_SRC]
                       ? (pins_clean.phase_a && !prev_raw_a)
                       : (!enc_ctrl[BIT_GATE] || pins_clean.phase_a);
    assign timer_up  = enc_ctrl[BIT_DIRECTION_FLAG_SRC] ? pins_clean.phase_b
                                              : direction_flag;

    timer_prescaler u_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .run      (timer_mode),
        .select   (enc_ctrl[PRESCALE_LSB +: 2]),
        .tick_in  (timer_src),
        .tick_out (timer_tick)
    );

    // Timer ticks drive the same counter
    assign count_event = quad_step || timer_tick;
    // Up on A leading, down on B leading
    assign count_up    = quad_mode ? step_up : timer_up;
    assign match_reset = count_event && count_up && (position == max_limit)
                         && (match_mode || timer_mode);

    // APB decode
    assign pready  = ce;
    assign access  = psel && penable && ce;
    assign wr      = access && pwrite;
    assign hit     = (paddr == OFS_ENC_CTRL) || (paddr == OFS_FILT_CTRL)
                     || (paddr == OFS_POSITION) || (paddr == OFS_MAX_LIMIT);
    assign pslverr = psel && penable && !hit;
    assign wr_enc  = wr && (paddr == OFS_ENC_CTRL);
    assign wr_filt = wr && (paddr == OFS_FILT_CTRL);
    assign wr_pos  = wr && (paddr == OFS_POSITION);
    assign wr_max  = wr && (paddr == OFS_MAX_LIMIT);

    always_comb begin
        next_position = position;
        if (count_event) begin
            if (count_up) begin
                next_position = 16'(position + 16'h0001);
            end else if ((match_mode || timer_mode)
                         && (position == 16'h0000)) begin
                next_position = max_limit;
            end else begin
                next_position = 16'(position - 16'h0001);
            end
        end
        // Zero loaded in the event cycle
        if (match_reset || index_reset) begin
            next_position = 16'h0000;
        end
        // Software write takes precedence over counting
        // Byte writes while counting may tear
        if (wr_pos) begin
            next_position = merge_bytes(position, pwdata[15:0], pstrb[1:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position <= POSITION_RESET;
        end else if (ce) begin
            position <= next_position;
        end
    end

    // Byte lanes honoured on every register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_ctrl  <= ENC_CTRL_RESET;
            filt_ctrl <= FILT_CTRL_RESET;
            max_limit <= MAX_LIMIT_RESET;
        end else if (ce) begin
            if (wr_enc) begin
                enc_ctrl <= merge_bytes(enc_ctrl, pwdata[15:0], pstrb[1:0])
                            & ENC_CTRL_WMASK;
            end
            if (wr_filt && pstrb[0]) begin
                filt_ctrl <= pwdata[7:0];
            end
            if (wr_max) begin
                max_limit <= merge_bytes(max_limit, pwdata[15:0],
                                         pstrb[1:0]);
            end
        end
    end

    // Direction follows the decoder; in timer mode software sets it, or phase B when the source bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_flag <= 1'b0;
        end else if (ce) begin
            if (quad_step) begin
                direction_flag <= step_up;
            end else if (timer_mode && !enc_ctrl[BIT_DIRECTION_FLAG_SRC]
                         && wr_enc && pstrb[1]) begin
                direction_flag <= pwdata[BIT_DIRECTION];
            end else if (timer_mode && enc_ctrl[BIT_DIRECTION_FLAG_SRC]) begin
                direction_flag <= pins_clean.phase_b;
            end
        end
    end

    // Error flag writable; a new error wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_error_flag <= 1'b0;
        end else if (ce) begin
            if (phase_error) begin
                count_error_flag <= 1'b1;
            end else if (wr_enc && pstrb[1]) begin
                count_error_flag <= pwdata[BIT_CNT_ERR];
            end
        end
    end

    // One pulse per reset, match or error event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request <= 1'b0;
            count_pulse <= 1'b0;
            count_dir   <= 1'b0;
            dir_pin_out <= 1'b0;
            dir_pin_oe  <= 1'b0;
        end else if (ce) begin
            irq_request <= match_reset || index_reset || phase_error;
            count_pulse <= quad_step;
            count_dir   <= quad_step ? step_up : count_dir;
            dir_pin_out <= direction_flag;
            dir_pin_oe  <= enc_ctrl[BIT_DIR_OE];
        end
    end

    always_comb begin
        enc_status                = enc_ctrl;
        enc_status[BIT_CNT_ERR]   = count_error_flag;
        enc_status[BIT_INDEX_PIN] = pins_clean.index;
        enc_status[BIT_DIRECTION] = direction_flag;
    end

    // Read data captured in the setup cycle, so it is a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable) begin
            case (paddr)
                OFS_ENC_CTRL:  prdata <= {16'h0000, enc_status};
                OFS_FILT_CTRL: prdata <= {24'h000000, filt_ctrl};
                OFS_POSITION:  prdata <= {16'h0000, position};
                OFS_MAX_LIMIT: prdata <= {16'h0000, max_limit};
                default:       prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // quadrature_position_decoder

/* quad_encoder_model.sv */
// Behavioural incremental encoder driving the phase and index pins
module quad_encoder_model
    import qpd_pkg::*;
(
    // Clock and pins
    input  wire logic pclk,
    output encoder_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase_idx = 2'h0;

    initial pins = '0;

    // Long gap so each edge is counted before the next arrives
    task automatic move(input logic [1:0] delta);
        @(posedge pclk);
        phase_idx = phase_idx + delta;
        pins.phase_a <= phase_idx[1] ^ phase_idx[0];
        pins.phase_b <= phase_idx[1];
        repeat (10) @(posedge pclk);
    endtask

    // forward order 00 10 11 01
    task automatic step(input logic fwd);
        move(fwd ? 2'h1 : 2'h3);
    endtask

    // Both phases at once, which a sound encoder never does
    task automatic glitch();
        move(2'h2);
    endtask

    task automatic index_pulse();
        @(posedge pclk);
        pins.index <= 1'b1;
        repeat (6) @(posedge pclk);
        pins.index <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask
endmodule // quad_encoder_model

/* qpd_chk.sv */
// Port-level concurrent checks for the quadrature position decoder
module qpd_chk
    import qpd_pkg::*;
(
    // Clock, reset, enable
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          ce,
    // APB
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // Encoder side
    input wire encoder_pins_s pins_raw,
    input wire logic          count_pulse,
    input wire logic          count_dir,
    input wire logic          dir_pin_out,
    input wire logic          dir_pin_oe,
    input wire logic          irq_request
);
    logic [2:0] mode_q;
    logic       filt_q;
    logic       acc;
    logic       mapped;

    assign acc = psel && penable && ce;
    assign mapped = paddr inside {OFS_ENC_CTRL, OFS_FILT_CTRL,
                                  OFS_POSITION, OFS_MAX_LIMIT};

    // Shadow copies; edge checks only hold with the filter bypassed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_OFF;
        end else if (acc && pwrite && paddr == OFS_ENC_CTRL && pstrb[1]) begin
            mode_q <= pwdata[10:8];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_q <= 1'b0;
        end else if (acc && pwrite && paddr == OFS_FILT_CTRL && pstrb[0]) begin
            filt_q <= pwdata[BIT_FILT_EN];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_follow_a: assert property (pready == ce)
        else $error("pready differs from ce");
    slave_error_a: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    unmapped_zero_a: assert property (acc && !pwrite && !mapped
        |-> prdata == 32'h00000000) else $error("unmapped read not zero");
    reserved_zero_a: assert property (acc && !pwrite
        && paddr == OFS_ENC_CTRL |-> prdata[14] == 1'b0
        && prdata[31:16] == 16'h0000) else $error("reserved bits set");
    dir_enable_a: assert property (acc && pwrite && pstrb[0]
        && paddr == OFS_ENC_CTRL
        |-> ##2 dir_pin_oe == $past(pwdata[BIT_DIR_OE], 2))
        else $error("dir_pin_oe not the written bit");
    forward_count_a: assert property (mode_q[2] && !filt_q
        && $changed(pins_raw.phase_a) && $stable(pins_raw.phase_b)
        && pins_raw.phase_a != pins_raw.phase_b
        |-> ##[2:5] (count_pulse && count_dir)) else $error("no up count");
    reverse_count_a: assert property (mode_q[2] && !filt_q
        && $changed(pins_raw.phase_a) && $stable(pins_raw.phase_b)
        && pins_raw.phase_a == pins_raw.phase_b
        |-> ##[2:5] (count_pulse && !count_dir)) else $error("no down count");
    quad_b_edge_a: assert property (mode_q[2:1] == 2'h3 && !filt_q
        && $changed(pins_raw.phase_b) && $stable(pins_raw.phase_a)
        |-> ##[2:5] count_pulse) else $error("x4 missed phase B edge");
    double_b_skip_a: assert property (mode_q[2:1] == 2'h2 && !filt_q
        && $changed(pins_raw.phase_b) && $stable(pins_raw.phase_a)
        |-> ##2 !count_pulse [*4]) else $error("x2 counted phase B edge");
    phase_error_a: assert property (mode_q[2] && !filt_q
        && $changed(pins_raw.phase_a) && $changed(pins_raw.phase_b)
        |-> ##[2:5] irq_request) else $error("no request on phase error");
    irq_single_a: assert property (irq_request |=> !irq_request)
        else $error("irq_request longer than one cycle");
endmodule // qpd_chk

bind quadrature_position_decoder qpd_chk chk_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_raw(pins_raw), .count_pulse(count_pulse), .count_dir(count_dir),
    .dir_pin_out(dir_pin_out), .dir_pin_oe(dir_pin_oe),
    .irq_request(irq_request)
);

/* quadrature_position_decoder_bench.sv */
// Self-checking bench for the quadrature position decoder
module quadrature_position_decoder_bench
    import qpd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0]  OFS_LIST [4] = '{OFS_ENC_CTRL, OFS_FILT_CTRL,
                                             OFS_POSITION, OFS_MAX_LIMIT};
    localparam logic [15:0] RST_LIST [4] = '{ENC_CTRL_RESET,
        {8'h00, FILT_CTRL_RESET}, POSITION_RESET, MAX_LIMIT_RESET};
    localparam int          SHIFTS [4]   = '{0, 3, 6, 8};

    logic          pclk    = 1'b0;
    logic          presetn = 1'b0;
    logic          psel    = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite  = 1'b0;
    logic [7:0]    paddr   = 8'h00;
    logic [31:0]   pwdata  = 32'h00000000;
    logic [3:0]    pstrb   = 4'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    encoder_pins_s pins_raw;
    logic          count_pulse;
    logic          count_dir;
    logic          dir_pin_out;
    logic          dir_pin_oe;
    logic          irq_request;
    int            failures     = 0;
    int            total_checks = 0;
    logic [31:0]   rd;
    logic          err;
    logic [15:0]   r0;
    logic [15:0]   lim;

    always #20 pclk = ~pclk;

    quadrature_position_decoder dut_u (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_raw(pins_raw), .count_pulse(count_pulse),
        .count_dir(count_dir), .dir_pin_out(dir_pin_out),
        .dir_pin_oe(dir_pin_oe), .irq_request(irq_request)
    );

    quad_encoder_model enc_u (.pclk(pclk), .pins(pins_raw));

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [15:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            $display("BAD %0t no pready", $time);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d, 4'h3);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 16'h0000, 4'h3);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo,
                           input logic [15:0] hi, input string what);
        total_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            failures++;
            $display("BAD %0t %s got %h", $time, what, got);
        end
    endtask

    task automatic steps(input logic fwd, input int n);
        repeat (n) enc_u.step(fwd);
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Tests need about 2500 cycles; eight times that is a hang
    initial begin
        #800000;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdr(OFS_LIST[i]);
            chk(rd, {16'h0000, RST_LIST[i]}, "reset value");
        end
        rdr(8'h10);
        chk({31'h0, err}, 32'h1, "unmapped error");
        wr(OFS_FILT_CTRL, 16'h0007);
        rdr(OFS_FILT_CTRL);
        chk(rd, 32'h7, "filter readback");
        wr(OFS_FILT_CTRL, 16'h0000);
        $display("test registers done");
        wr(OFS_POSITION, 16'h1234);
        rdr(OFS_POSITION);
        chk(rd, 32'h1234, "position word");
        apb(1'b1, OFS_POSITION, 16'hAB00, 4'h2);
        rdr(OFS_POSITION);
        chk(rd, 32'hAB34, "position high byte");
        $display("test access done");
        wr(OFS_MAX_LIMIT, 16'h0005);
        wr(OFS_POSITION, 16'h0000);
        wr(OFS_ENC_CTRL, 16'h0778);
        steps(1'b1, 4);
        rdr(OFS_POSITION);
        chk(rd, 32'h4, "x4 forward");
        rdr(OFS_ENC_CTRL);
        chk(rd & 32'h0800, 32'h0800, "direction up");
        chk({31'h0, dir_pin_out}, 32'h1, "direction pin up");
        steps(1'b0, 2);
        rdr(OFS_POSITION);
        chk(rd, 32'h2, "x4 reverse");
        rdr(OFS_ENC_CTRL);
        chk(rd & 32'h0800, 32'h0, "direction down");
        chk({31'h0, dir_pin_out}, 32'h0, "direction pin down");
        steps(1'b1, 4);
        rdr(OFS_POSITION);
        chk(rd, 32'h0, "match reset");
        steps(1'b0, 1);
        rdr(OFS_POSITION);
        chk(rd, 32'h5, "under zero loads max");
        $display("test x4 match done");
        wr(OFS_MAX_LIMIT, 16'hFFFF);
        wr(OFS_ENC_CTRL, 16'h0500);
        wr(OFS_POSITION, 16'h0000);
        steps(1'b1, 4);
        rdr(OFS_POSITION);
        chk(rd, 32'h2, "x2 cycle");
        $display("test x2 done");
        wr(OFS_ENC_CTRL, 16'h0600);
        wr(OFS_POSITION, 16'h0010);
        enc_u.index_pulse();
        rdr(OFS_POSITION);
        chk(rd, 32'h10, "index ignored");
        wr(OFS_ENC_CTRL, 16'h0604);
        enc_u.index_pulse();
        rdr(OFS_POSITION);
        chk(rd, 32'h0, "index reset");
        $display("test index done");
        wr(OFS_ENC_CTRL, 16'h0700);
        enc_u.glitch();
        rdr(OFS_ENC_CTRL);
        chk(rd & 32'h8000, 32'h8000, "error flag set");
        rdr(OFS_POSITION);
        chk(rd, 32'h0, "no count on error");
        wr(OFS_ENC_CTRL, 16'h0700);
        rdr(OFS_ENC_CTRL);
        chk(rd & 32'h8000, 32'h0, "error flag cleared");
        $display("test error done");
        for (int ps = 0; ps < 4; ps++) begin
            wr(OFS_ENC_CTRL, 16'h0100 | 16'(ps << 3));
            wr(OFS_ENC_CTRL, 16'h0900 | 16'(ps << 3));
            rdr(OFS_POSITION);
            r0 = rd[15:0];
            repeat (512) @(posedge pclk);
            rdr(OFS_POSITION);
            lim = 16'(512 >> SHIFTS[ps]);
            chk_rng(rd[15:0] - r0, lim, lim + 16'h4, "prescale");
        end
        wr(OFS_ENC_CTRL, 16'h0902);
        rdr(OFS_POSITION);
        r0 = rd[15:0];
        steps(1'b1, 8);
        rdr(OFS_POSITION);
        chk({16'h0000, rd[15:0] - r0}, 32'h2, "phase A clock");
        $display("test timer done");
        final_report();
    end
endmodule // quadrature_position_decoder_bench
